//--- hdl/dcp_pkg.sv
package dcp_pkg;

    // ------------------------------------------------------------
    // Control memory codes
    // ------------------------------------------------------------
    localparam logic [3:0] CODE_UNASSIGNED = 4'h0;
    localparam logic [3:0] CODE_SW64       = 4'h1;
    localparam logic [3:0] CODE_SW16_B10   = 4'h4;
    localparam logic [3:0] CODE_SW16_B32   = 4'h5;
    localparam logic [3:0] CODE_SW16_B54   = 4'h6;
    localparam logic [3:0] CODE_SW16_B76   = 4'h7;
    localparam logic [3:0] CODE_CI_EVEN    = 4'h8;
    localparam logic [3:0] CODE_CI_EVEN_DN = 4'hA;
    localparam logic [3:0] CODE_DS_HIZ     = 4'hB;

    // ------------------------------------------------------------
    // Memory access command encodings
    // ------------------------------------------------------------
    localparam logic [3:0] CMD_WRITE_CODE_DATA = 4'h7;
    localparam logic [7:0] CMD_TRISTATE_ONE    = 8'h60;
    localparam logic [7:0] CMD_CM_RESET        = 8'h80;
    localparam logic [7:0] CMD_READ_CM         = 8'h40;

    // ------------------------------------------------------------
    // Register offsets of the plain register port
    // ------------------------------------------------------------
    localparam logic [3:0] REG_MEM_DATA    = 4'h0;
    localparam logic [3:0] REG_MEM_ADDR    = 4'h1;
    localparam logic [3:0] REG_MEM_CTRL    = 4'h2;
    localparam logic [3:0] REG_READ_CODE   = 4'h3;
    localparam logic [3:0] REG_READ_DATA   = 4'h4;
    localparam logic [3:0] REG_CHG_QUEUE   = 4'h5;
    localparam logic [3:0] REG_STATUS      = 4'h6;
    localparam logic [3:0] REG_CONFIG      = 4'h7;

    // Field positions.
    localparam int ADDR_DIR_BIT   = 7;
    localparam int CFG_HS_BIT     = 0;
    localparam int CFG_SUBSEL_LO  = 1;
    localparam int CFG_SUBSEL_HI  = 2;
    localparam int ST_CHG_BIT     = 0;
    localparam int ST_QFULL_BIT   = 1;
    localparam int ST_BUSY_BIT    = 2;

    // Frame timing.
    localparam int FRAME_US       = 125;
    localparam int SLOTS          = 32;
    localparam int CLK_MHZ        = 100;
    localparam int FRAME_CYCLES   = FRAME_US * CLK_MHZ;

    typedef struct packed {
        logic [3:0] code;
        logic [7:0] data;
    } dcp_cm_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } dcp_bus_s;

endpackage

//--- hdl/dcp_top.sv
`timescale 1ns/1ns
module dcp_top
#(
    parameter int SLOTS_P = 32,
    parameter int QDEPTH  = 16
)
(
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic [3:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [7:0]        reg_rdata,
    output logic                   ci_change_irq,
    input  wire logic              line_clk,
    input  wire logic              line_frame,
    input  wire logic              line_rx,
    output logic                   line_tx,
    output logic                   line_tx_oe,
    input  wire logic              pcm_rx,
    output logic                   pcm_tx,
    output logic                   pcm_tx_oe,
    input  wire logic              hs_mode,
    input  wire logic [1:0]        hs_bits
);
    import dcp_pkg::*;

    initial
    begin
        if (SLOTS_P != 32 || QDEPTH < 2 || QDEPTH > 256)
            $error("dcp_top: unsupported parameters");
    end

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [3:0] s1_q, s2_q, s1_d;
    logic       lclk_prev_q, lclk_prev_d;
    always_comb
    begin
        s1_d = {line_clk, line_frame, line_rx, pcm_rx};
        lclk_prev_d = s2_q[3];
    end
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_q        <= 4'h0;
            s2_q        <= 4'h0;
            lclk_prev_q <= 1'b0;
        end
        else
        begin
            s1_q        <= s1_d;
            s2_q        <= s1_q;
            lclk_prev_q <= lclk_prev_d;
        end
    end
    logic rise;
    assign rise = s2_q[3] && !lclk_prev_q;

    // ------------------------------------------------------------
    // Memories
    // ------------------------------------------------------------
    dcp_cm_s    cm_dn [SLOTS_P];
    dcp_cm_s    cm_up [SLOTS_P];
    logic [7:0] drive_mask [SLOTS_P];
    logic [3:0] ci_prev [SLOTS_P];
    logic [4:0] queue [QDEPTH];

    // ------------------------------------------------------------
    // Register port state
    // ------------------------------------------------------------
    logic [7:0] mdata_q, maddr_q, cfg_q, rdata_q, rcode_q, rdat_q;
    logic [7:0] mdata_d, maddr_d, cfg_d, rdata_d, rcode_d, rdat_d;
    logic [5:0] clr_idx_q, clr_idx_d;
    logic       clr_busy_q, clr_busy_d;

    // Line side bit position.
    logic [2:0] bit_q, bit_d;
    logic [4:0] slot_q, slot_d;
    logic [7:0] rxsh_q, rxsh_d;
    logic [7:0] pcmsh_q, pcmsh_d;
    logic       tx_q, tx_d, oe_q, oe_d, ptx_q, ptx_d, poe_q, poe_d;
    logic       irq_q, irq_d;

    // Queue pointers.
    logic [8:0] wp_q, rp_q, wp_d, rp_d;
    logic       push, pop;
    logic [4:0] push_val;
    logic       qempty, qfull;
    assign qempty = (wp_q == rp_q);
    assign qfull  = (wp_q - rp_q) == 9'(QDEPTH);

    // Per-bit line output from the current slot configuration.
    function automatic logic [1:0] tx_bit(input dcp_cm_s e, input dcp_cm_s o,
                                         input logic odd, input logic [2:0] b,
                                         input logic pcm, input logic hsm,
                                         input logic [1:0] hsb);
        logic [1:0] r;
        r = 2'b00;
        if (!odd)
            r = {1'b1, 1'b1};
        else if (b >= 3'd6)
        begin
            if (o.code == CODE_DS_HIZ)
                r = 2'b00;
            else if (o.code == CODE_SW64 || o.code[3:2] == 2'b01)
                r = {pcm, 1'b1};
        end
        else if (b >= 3'd2)
            r = {e.data[b], 1'b1};
        else if (o.code == CODE_SW64)
            r = {pcm & (hsm ? hsb[b[0]] : 1'b1), 1'b1};
        else
            r = {hsm ? hsb[b[0]] : e.data[b], 1'b1};
        return r;
    endfunction

    // PCM bit index selected by a 16 kbps code.
    function automatic logic [2:0] pcm_pos(input logic [3:0] c, input logic [2:0] b);
        return 3'({c[1:0], b[0]});
    endfunction

    logic       odd;
    logic [1:0] tb;
    dcp_cm_s    ev_dn, od_dn, od_up, ev_up;
    always_comb
    begin
        odd   = slot_q[0];
        ev_dn = cm_dn[{slot_q[4:1], 1'b0}];
        od_dn = cm_dn[{slot_q[4:1], 1'b1}];
        ev_up = cm_up[{slot_q[4:1], 1'b0}];
        od_up = cm_up[{slot_q[4:1], 1'b1}];
        tb    = tx_bit(ev_dn, od_dn, odd, 3'(7 - bit_q), s2_q[0], hs_mode, hs_bits);
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        mdata_d = mdata_q;
        maddr_d = maddr_q;
        cfg_d   = cfg_q;
        rcode_d = rcode_q;
        rdat_d  = rdat_q;
        rdata_d = 8'h00;
        clr_idx_d = clr_idx_q;
        clr_busy_d = clr_busy_q;
        bit_d = bit_q;
        slot_d = slot_q;
        rxsh_d = rxsh_q;
        pcmsh_d = pcmsh_q;
        tx_d = tx_q;
        oe_d = oe_q;
        ptx_d = ptx_q;
        poe_d = poe_q;
        push = 1'b0;
        push_val = slot_q;
        pop = 1'b0;
        if (reg_wr)
        begin
            unique case (reg_addr)
                REG_MEM_DATA: mdata_d = reg_wdata;
                REG_MEM_ADDR: maddr_d = reg_wdata;
                REG_CONFIG:   cfg_d   = reg_wdata;
                REG_MEM_CTRL:
                    if (reg_wdata == CMD_CM_RESET)
                    begin
                        clr_busy_d = 1'b1;
                        clr_idx_d = 6'h0;
                    end
                    else if (reg_wdata == CMD_READ_CM)
                    begin
                        rcode_d = {4'h0, maddr_q[ADDR_DIR_BIT] ?
                                   cm_up[maddr_q[4:0]].code : cm_dn[maddr_q[4:0]].code};
                        rdat_d  = maddr_q[ADDR_DIR_BIT] ?
                                  cm_up[maddr_q[4:0]].data : cm_dn[maddr_q[4:0]].data;
                    end
                default: ;
            endcase
        end
        if (reg_rd)
        begin
            unique case (reg_addr)
                REG_MEM_DATA:  rdata_d = mdata_q;
                REG_MEM_ADDR:  rdata_d = maddr_q;
                REG_MEM_CTRL:  rdata_d = 8'h00;
                REG_READ_CODE: rdata_d = rcode_q;
                REG_READ_DATA: rdata_d = rdat_q;
                REG_CHG_QUEUE:
                begin
                    rdata_d = qempty ? 8'h00 : {3'b000, queue[rp_q[7:0] % QDEPTH]};
                    pop = !qempty;
                end
                REG_STATUS:    rdata_d = {5'h0, clr_busy_q, qfull, !qempty};
                REG_CONFIG:    rdata_d = cfg_q;
                default:       rdata_d = 8'h00;
            endcase
        end
        if (clr_busy_q)
        begin
            clr_idx_d = clr_idx_q + 6'h1;
            if (clr_idx_q == 6'(SLOTS_P - 1))
                clr_busy_d = 1'b0;
        end
        if (rise)
        begin
            if (s2_q[2])
            begin
                bit_d = 3'h0;
                slot_d = 5'h0;
            end
            else
            begin
                bit_d = bit_q + 3'h1;
                if (bit_q == 3'h7)
                    slot_d = slot_q + 5'h1;
            end
            rxsh_d = {rxsh_q[6:0], s2_q[1]};
            pcmsh_d = {pcmsh_q[6:0], s2_q[0]};
            tx_d = tb[1];
            oe_d = tb[0];
            if (odd && od_up.code[3:2] == 2'b01)
            begin
                ptx_d = s2_q[1];
                poe_d = (3'(7 - bit_q) == pcm_pos(od_up.code, 3'(7 - bit_q)));
            end
            else if (odd && od_up.code == CODE_SW64)
            begin
                ptx_d = s2_q[1];
                poe_d = drive_mask[slot_q][3'(7 - bit_q)];
            end
            else
                poe_d = 1'b0;
            if (odd && bit_q == 3'h7 && ev_up.code == CODE_CI_EVEN)
            begin
                if (rxsh_q[5:2] != ci_prev[slot_q])
                begin
                    push = !qfull;
                    push_val = slot_q;
                end
            end
        end
    end

    always_comb
    begin
        wp_d = push ? wp_q + 9'h1 : wp_q;
        rp_d = pop ? rp_q + 9'h1 : rp_q;
        irq_d = irq_q;
        if (push)
            irq_d = 1'b1;
        else if (pop && (wp_q - rp_q) == 9'h1)
            irq_d = 1'b0;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mdata_q <= 8'h00;
            maddr_q <= 8'h00;
            cfg_q <= 8'h00;
            rcode_q <= 8'h00;
            rdat_q <= 8'h00;
            rdata_q <= 8'h00;
            clr_idx_q <= 6'h0;
            clr_busy_q <= 1'b0;
            bit_q <= 3'h0;
            slot_q <= 5'h0;
            rxsh_q <= 8'h00;
            pcmsh_q <= 8'h00;
            tx_q <= 1'b1;
            oe_q <= 1'b0;
            ptx_q <= 1'b1;
            poe_q <= 1'b0;
            irq_q <= 1'b0;
            wp_q <= 9'h0;
            rp_q <= 9'h0;
        end
        else
        begin
            mdata_q <= mdata_d;
            maddr_q <= maddr_d;
            cfg_q <= cfg_d;
            rcode_q <= rcode_d;
            rdat_q <= rdat_d;
            rdata_q <= rdata_d;
            clr_idx_q <= clr_idx_d;
            clr_busy_q <= clr_busy_d;
            bit_q <= bit_d;
            slot_q <= slot_d;
            rxsh_q <= rxsh_d;
            pcmsh_q <= pcmsh_d;
            tx_q <= tx_d;
            oe_q <= oe_d;
            ptx_q <= ptx_d;
            poe_q <= poe_d;
            irq_q <= irq_d;
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
    end

    // ------------------------------------------------------------
    // Memory writes
    // ------------------------------------------------------------
    // Memories carry no reset; the clear sweep gives cm_dn, cm_up and drive_mask defined values, but not ci_prev or queue.
    always_ff @(posedge clk_sys)
    begin
        if (clr_busy_q)
        begin
            cm_dn[clr_idx_q[4:0]] <= '{code: CODE_UNASSIGNED, data: 8'h00};
            cm_up[clr_idx_q[4:0]] <= '{code: CODE_UNASSIGNED, data: 8'h00};
            drive_mask[clr_idx_q[4:0]] <= 8'h00;
        end
        else if (reg_wr && reg_addr == REG_MEM_CTRL)
        begin
            if (reg_wdata[7:4] == CMD_WRITE_CODE_DATA)
            begin
                if (maddr_q[ADDR_DIR_BIT])
                    cm_up[maddr_q[4:0]] <= '{code: reg_wdata[3:0], data: mdata_q};
                else
                    cm_dn[maddr_q[4:0]] <= '{code: reg_wdata[3:0], data: mdata_q};
            end
            else if (reg_wdata == CMD_TRISTATE_ONE)
                drive_mask[maddr_q[4:0]] <= mdata_q;
        end
        if (push_val[0] && rise && odd && bit_q == 3'h7)
            ci_prev[slot_q] <= rxsh_q[5:2];
        if (push)
            queue[wp_q[7:0] % QDEPTH] <= push_val;
    end

    assign reg_rdata     = rdata_q;
    assign ci_change_irq = irq_q;
    assign line_tx       = tx_q;
    assign line_tx_oe    = oe_q;
    assign pcm_tx        = ptx_q;
    assign pcm_tx_oe     = poe_q;
endmodule

//--- sim/dcp_line_model.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Line-side transceiver model
// ------------------------------------------------------------
// The bus clock runs free because a framed subscriber bus never stops.
module dcp_line_model
(
    input  wire logic [3:0] ci_val,
    output logic            line_clk,
    output logic            line_frame,
    output logic            line_rx
);
    logic [7:0] slot_byte;
    logic [3:0] ci_frame;
    int         bit_i;

    initial
    begin
        line_clk   = 1'b0;
        line_frame = 1'b0;
        line_rx    = 1'b1;
        bit_i      = 0;
        ci_frame   = ci_val;
        forever
        begin
            #80 line_clk = 1'b1;
            #80 line_clk = 1'b0;
            // C/I is latched per frame so a mid-frame change never tears a slot.
            if (bit_i == 0)
                ci_frame = ci_val;
            slot_byte  = (bit_i / 8 == 3) ? {2'b11, ci_frame, 2'b11} : 8'hFF;
            line_frame = (bit_i == 0);
            line_rx    = slot_byte[7 - bit_i % 8];
            bit_i      = (bit_i + 1) % 256;
        end
    end
endmodule

//--- sim/dcp_top_assertions.sv
`timescale 1ns/1ns
module dcp_chk
    import dcp_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       ci_change_irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------
    // Cycles since the last control memory clear
    // ------------------------------------------------------------
    logic [5:0] since_clr_q;
    logic [5:0] since_clr_d;
    logic       clr_cmd;
    logic       st_rd;
    logic       pop;

    always_comb
    begin
        clr_cmd     = reg_wr && reg_addr == REG_MEM_CTRL && reg_wdata == CMD_CM_RESET;
        st_rd       = reg_rd && reg_addr == REG_STATUS;
        pop         = reg_rd && reg_addr == REG_CHG_QUEUE;
        since_clr_d = clr_cmd ? 6'h00 : (since_clr_q == 6'h3F ? 6'h3F : since_clr_q + 6'h01);
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            since_clr_q <= 6'h3F;
        else
            since_clr_q <= since_clr_d;
    end

    sequence s_wr_code;
        reg_wr && reg_addr == REG_MEM_CTRL && reg_wdata[7:4] == CMD_WRITE_CODE_DATA;
    endsequence
    sequence s_latch;
        reg_wr && reg_addr == REG_MEM_CTRL && reg_wdata == CMD_READ_CM;
    endsequence
    sequence s_cfg_wr;
        reg_wr && reg_addr == REG_CONFIG;
    endsequence

    AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    AST_UNMAPPED: assert property (reg_rd && reg_addr[3] |=> reg_rdata == 8'h00)
        else $error("unmapped read returned data");
    AST_CFG_BACK: assert property (s_cfg_wr ##1 (reg_rd && reg_addr == REG_CONFIG)
        |=> reg_rdata[CFG_HS_BIT] == $past(reg_wdata[CFG_HS_BIT], 2))
        else $error("config bit not read back");
    AST_BUSY_SET: assert property (st_rd && since_clr_q == 6'h00 |=> reg_rdata[ST_BUSY_BIT])
        else $error("clear not busy right after command");
    AST_BUSY_BOUND: assert property (st_rd && since_clr_q > 6'd33 |=> !reg_rdata[ST_BUSY_BIT])
        else $error("clear still busy after 32 cycles");
    AST_CODE_BACK: assert property (s_wr_code ##1 s_latch ##1 (reg_rd && reg_addr == REG_READ_CODE)
        |=> reg_rdata[3:0] == $past(reg_wdata[3:0], 3))
        else $error("code field not written");
    AST_IRQ_STATUS: assert property (st_rd && $stable(ci_change_irq)
        |=> $stable(ci_change_irq) && reg_rdata[ST_CHG_BIT] == ci_change_irq)
        else $error("status change bit disagrees with irq");
    AST_IRQ_FALL: assert property ($fell(ci_change_irq) |-> $past(pop, 1) || $past(pop, 2))
        else $error("irq fell without a queue read");
endmodule

bind dcp_top dcp_chk u_chk
(
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .reg_addr     (reg_addr),
    .reg_wdata    (reg_wdata),
    .reg_wr       (reg_wr),
    .reg_rd       (reg_rd),
    .reg_rdata    (reg_rdata),
    .ci_change_irq(ci_change_irq)
);

//--- sim/testbench.sv
`timescale 1ns/1ns
module testbench;
    import dcp_pkg::*;
    logic       clk_sys, rst_n, reg_wr, reg_rd, ci_change_irq, line_clk, line_frame;
    logic       line_rx, line_tx, line_tx_oe, pcm_tx, pcm_tx_oe, hs_mode;
    logic [3:0] reg_addr, ci_val;
    logic [7:0] reg_wdata, reg_rdata, v;
    logic [1:0] hs_bits;
    logic [3:0] codes [9] = '{CODE_UNASSIGNED, CODE_SW64, CODE_SW16_B10, CODE_SW16_B32,
        CODE_SW16_B54, CODE_SW16_B76, CODE_CI_EVEN, CODE_CI_EVEN_DN, CODE_DS_HIZ};
    int         n_errors, total_checks;

    dcp_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ci_change_irq(ci_change_irq), .line_clk(line_clk), .line_frame(line_frame),
        .line_rx(line_rx), .line_tx(line_tx), .line_tx_oe(line_tx_oe),
        .pcm_rx(1'b1), .pcm_tx(pcm_tx), .pcm_tx_oe(pcm_tx_oe),
        .hs_mode(hs_mode), .hs_bits(hs_bits));
    dcp_line_model u_line (.ci_val(ci_val), .line_clk(line_clk),
        .line_frame(line_frame), .line_rx(line_rx));

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Register port cycles
    // ------------------------------------------------------------
    // A write leaves its strobe up so writes run back to back; idle drops it.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        reg_rd    <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        reg_wr   <= 1'b0;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge clk_sys);
    endtask
    task automatic idle(input int n);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic cm(input logic dir, input logic [4:0] s, input logic [3:0] c,
                      input logic [7:0] d);
        wr(REG_MEM_DATA, d);
        wr(REG_MEM_ADDR, {dir, 2'b00, s});
        wr(REG_MEM_CTRL, {CMD_WRITE_CODE_DATA, c});
    endtask
    task automatic rdcm(input logic dir, input logic [4:0] s, input logic [3:0] c,
                        input logic [7:0] d);
        wr(REG_MEM_ADDR, {dir, 2'b00, s});
        wr(REG_MEM_CTRL, CMD_READ_CM);
        rd(REG_READ_CODE, v);
        chk(v, {4'h0, c}, "code");
        rd(REG_READ_DATA, v);
        chk(v, d, "data");
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        chk({4'h0, ci_change_irq, line_tx_oe, pcm_tx_oe, line_tx & pcm_tx}, 8'h01, "rst");
        chk(reg_rdata, 8'h00, "rst rdata");
    endtask
    task automatic t_clear;
        wr(REG_MEM_CTRL, CMD_CM_RESET);
        rd(REG_STATUS, v);
        chk(v[ST_BUSY_BIT], 1'b1, "busy");
        for (int i = 0; i < 40 && v[ST_BUSY_BIT] !== 1'b0; i++)
            rd(REG_STATUS, v);
        chk(v[ST_BUSY_BIT], 1'b0, "busy end");
        for (int i = 0; i < 64; i++)
            rdcm(i[5], i[4:0], CODE_UNASSIGNED, 8'h00);
    endtask
    task automatic t_codes;
        for (int i = 0; i < 9; i++)
        begin
            cm(1'b1, 5'd11, codes[(i + 4) % 9], ~8'(i * 37));
            cm(1'b0, 5'd11, codes[i], 8'(i * 37));
            wr(REG_MEM_CTRL, CMD_READ_CM);
            rd(REG_READ_CODE, v);
            chk(v, {4'h0, codes[i]}, "down code");
            rd(REG_READ_DATA, v);
            chk(v, 8'(i * 37), "down data");
            rdcm(1'b1, 5'd11, codes[(i + 4) % 9], ~8'(i * 37));
        end
    endtask
    task automatic t_regs;
        for (int a = 8; a < 16; a++)
        begin
            wr(4'(a), 8'hA5);
            rd(4'(a), v);
            chk(v, 8'h00, "unmapped");
        end
        for (int b = 0; b < 2; b++)
        begin
            hs_mode <= b[0];
            wr(REG_CONFIG, 8'(b));
            rd(REG_CONFIG, v);
            chk(v[CFG_HS_BIT], b[0], "config");
        end
    endtask
    task automatic t_change;
        cm(1'b1, 5'd2, CODE_CI_EVEN, 8'hFF);
        cm(1'b1, 5'd3, CODE_UNASSIGNED, 8'h00);
        cm(1'b0, 5'd2, CODE_CI_EVEN, 8'hC3);
        cm(1'b0, 5'd3, CODE_DS_HIZ, 8'h00);
        idle(3 * 4096);
        for (int i = 0; i < 20 && ci_change_irq === 1'b1; i++)
            rd(REG_CHG_QUEUE, v);
        idle(2 * 4096);
        chk(ci_change_irq, 1'b0, "no change");
        ci_val <= 4'hA;
        for (int i = 0; i < 2 * 4096 + 300 && ci_change_irq !== 1'b1; i++)
            @(posedge clk_sys);
        chk(ci_change_irq, 1'b1, "change irq");
        rd(REG_STATUS, v);
        chk(v[ST_CHG_BIT], 1'b1, "queued");
        rd(REG_CHG_QUEUE, v);
        chk(v, 8'h03, "queued slot");
        idle(3);
        chk(ci_change_irq, 1'b0, "one entry");
        rd(REG_STATUS, v);
        chk(v[ST_CHG_BIT], 1'b0, "empty");
    endtask
    // One frame is 4096 system cycles and a line bit lasts 16 of them.
    task automatic t_line(input int exp_hiz, input int exp_pdrv);
        int n_hiz;
        int n_pdrv;
        n_hiz  = 0;
        n_pdrv = 0;
        idle(32);
        repeat (4096)
        begin
            @(posedge clk_sys);
            n_hiz  += (line_tx_oe === 1'b0);
            n_pdrv += (pcm_tx_oe === 1'b1);
        end
        chk(8'(n_hiz / 16), 8'(exp_hiz), "line float bits");
        chk(8'(n_pdrv / 16), 8'(exp_pdrv), "pcm drive bits");
    endtask
    task automatic t_central;
        cm(1'b0, 5'd12, CODE_CI_EVEN_DN, 8'hC3);
        cm(1'b1, 5'd12, CODE_CI_EVEN, 8'hFF);
        cm(1'b0, 5'd13, CODE_SW16_B54, 8'h11);
        cm(1'b1, 5'd13, CODE_SW16_B10, 8'hA4);
        cm(1'b1, 5'd15, CODE_SW64, 8'hA4);
        wr(REG_MEM_DATA, 8'h0C);
        wr(REG_MEM_ADDR, 8'h8F);
        wr(REG_MEM_CTRL, CMD_TRISTATE_ONE);
        t_line(30, 6);
        cm(1'b0, 5'd13, CODE_DS_HIZ, 8'h00);
        t_line(32, 6);
    endtask

    initial
    begin
        {n_errors, total_checks} = 0;
        {rst_n, reg_wr, reg_rd, hs_mode} = 4'b0000;
        {reg_addr, reg_wdata} = 12'h000;
        hs_bits = 2'b11;
        ci_val  = 4'h5;
        repeat (12) @(posedge clk_sys);
        t_reset;
        rst_n <= 1'b1;
        @(posedge clk_sys);
        t_clear;
        t_codes;
        t_regs;
        t_change;
        t_central;
        idle(2);
        stop_test;
    end

    initial
    begin
        #800000;
        n_errors++;
        stop_test;
    end
endmodule
